// File: core/pif_pkg.sv
package pif_pkg;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] PIF_FLAGS_OFF = 8'h0C;
    localparam logic [7:0] PIF_ENABLE_OFF = 8'h10;
    localparam logic [7:0] PIF_CTRL_OFF = 8'h14;
    localparam logic [7:0] PIF_RXDATA_OFF = 8'h18;
    localparam logic [7:0] PIF_TXDATA_OFF = 8'h1C;
    localparam logic [7:0] PIF_STATUS_OFF = 8'h20;
    localparam logic [7:0] PIF_MASK_OFF = 8'h24;
    // ****************************************
    // field positions
    // ****************************************
    localparam int PIF_PSP_BIT = 7;
    localparam int PIF_ADC_BIT = 6;
    localparam int PIF_RX_BIT = 5;
    localparam int PIF_TX_BIT = 4;
    localparam int PIF_SSP_BIT = 3;
    localparam int PIF_GATE_BIT = 0;
    localparam int PIF_RXOVR_BIT = 1;
    localparam int PIF_TXDONE_BIT = 2;
    // flags software may write
    localparam logic [7:0] PIF_WR_MASK = 8'hCF;
    // ****************************************
    // reset values (flags reset also sets the TX bit) and response codes
    // ****************************************
    localparam logic [7:0] PIF_FLAGS_RST = 8'h00;
    localparam logic [7:0] PIF_ENABLE_RST = 8'h00;
    localparam logic [7:0] PIF_CTRL_RST = 8'h00;
    localparam logic [7:0] PIF_STATUS_RST = 8'h00;
    localparam logic [7:0] PIF_MASK_RST = 8'h00;
    localparam logic [1:0] PIF_RESP_OKAY = 2'h0;
    localparam logic [1:0] PIF_RESP_SLVERR = 2'h2;
endpackage : pif_pkg

// File: core/pif_flags.sv
// Design decision made here: the AXI4-Lite interface to the registers.
module pif_flags (
    input wire logic clk,
    input wire logic reset,
    // ****************************************
    // axi4-lite slave
    // ****************************************
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // ****************************************
    // peripheral events (same clock)
    // ****************************************
    input wire logic psp_access_done,
    input wire logic adc_conv_done,
    input wire logic ssp_xfer_done,
    input wire logic rx_byte_in,
    input wire logic [7:0] rx_byte,
    input wire logic tx_byte_taken,
    output logic [7:0] tx_byte,
    output logic tx_byte_valid,
    input wire logic global_irq_gate,
    output logic cpu_irq,
    output logic irq
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] enable;
        logic [7:0] ctrl;
        logic [7:0] rx_data;
        logic [7:0] tx_data;
        logic [7:0] status;
        logic [7:0] mask;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic cpu_irq;
        logic irq;
        logic tx_full;
    } pif_state_type;

    pif_state_type st_ff;
    pif_state_type nxt_st;

    function automatic logic is_mapped(input logic [7:0] a);
        return a == pif_pkg::PIF_FLAGS_OFF || a == pif_pkg::PIF_ENABLE_OFF
            || a == pif_pkg::PIF_CTRL_OFF || a == pif_pkg::PIF_RXDATA_OFF
            || a == pif_pkg::PIF_TXDATA_OFF || a == pif_pkg::PIF_STATUS_OFF
            || a == pif_pkg::PIF_MASK_OFF;
    endfunction : is_mapped

    logic do_write;
    logic do_read;
    logic rx_read;
    logic tx_write;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;
    logic [7:0] evt;

    always_comb begin
        nxt_st = st_ff;
        wbyte = st_ff.w_data[7:0];
        do_write = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
        do_read = s_axi_arvalid && st_ff.arready;
        rx_read = do_read && s_axi_araddr == pif_pkg::PIF_RXDATA_OFF;
        tx_write = do_write && st_ff.w_strb[0] && st_ff.aw_addr == pif_pkg::PIF_TXDATA_OFF;
        rd_byte = 8'h00;
        evt = 8'h00;
        // ****************************************
        // write channel capture
        // ****************************************
        nxt_st.awready = !st_ff.aw_got && !(s_axi_awvalid && st_ff.awready);
        nxt_st.wready = !st_ff.w_got && !(s_axi_wvalid && st_ff.wready);
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = is_mapped(st_ff.aw_addr) ? pif_pkg::PIF_RESP_OKAY
                                                    : pif_pkg::PIF_RESP_SLVERR;
            if (st_ff.w_strb[0]) begin
                unique case (st_ff.aw_addr)
                    pif_pkg::PIF_FLAGS_OFF: begin
                        nxt_st.flags = (st_ff.flags & ~pif_pkg::PIF_WR_MASK)
                                     | (wbyte & pif_pkg::PIF_WR_MASK);
                    end
                    pif_pkg::PIF_ENABLE_OFF: nxt_st.enable = wbyte;
                    pif_pkg::PIF_CTRL_OFF: nxt_st.ctrl = wbyte;
                    pif_pkg::PIF_TXDATA_OFF: nxt_st.tx_data = wbyte;
                    pif_pkg::PIF_STATUS_OFF: nxt_st.status = st_ff.status & ~wbyte;
                    pif_pkg::PIF_MASK_OFF: nxt_st.mask = wbyte;
                    default: ;
                endcase
            end
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.awready = 1'b1;
            nxt_st.wready = 1'b1;
        end
        // ****************************************
        // read channel
        // ****************************************
        unique case (s_axi_araddr)
            pif_pkg::PIF_FLAGS_OFF: rd_byte = st_ff.flags;
            pif_pkg::PIF_ENABLE_OFF: rd_byte = st_ff.enable;
            pif_pkg::PIF_CTRL_OFF: rd_byte = st_ff.ctrl;
            pif_pkg::PIF_RXDATA_OFF: rd_byte = st_ff.rx_data;
            pif_pkg::PIF_TXDATA_OFF: rd_byte = st_ff.tx_data;
            pif_pkg::PIF_STATUS_OFF: rd_byte = st_ff.status;
            pif_pkg::PIF_MASK_OFF: rd_byte = st_ff.mask;
            default: rd_byte = 8'h00;
        endcase
        nxt_st.arready = !st_ff.rvalid && !do_read;
        if (do_read) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = {24'h000000, rd_byte};
            nxt_st.rresp = is_mapped(s_axi_araddr) ? pif_pkg::PIF_RESP_OKAY
                                                   : pif_pkg::PIF_RESP_SLVERR;
        end
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
            nxt_st.arready = 1'b1;
        end
        // ****************************************
        // flags: set wins over software clear
        // ****************************************
        evt[pif_pkg::PIF_PSP_BIT] = psp_access_done;
        evt[pif_pkg::PIF_ADC_BIT] = adc_conv_done;
        evt[pif_pkg::PIF_SSP_BIT] = ssp_xfer_done;
        nxt_st.flags = nxt_st.flags | evt;
        // receive buffer: full on arrival, empty only on data read
        if (rx_byte_in) begin
            nxt_st.rx_data = rx_byte;
            if (st_ff.flags[pif_pkg::PIF_RX_BIT]) begin
                nxt_st.status[pif_pkg::PIF_RXOVR_BIT] = 1'b1;
            end
            nxt_st.flags[pif_pkg::PIF_RX_BIT] = 1'b1;
        end else if (rx_read) begin
            nxt_st.flags[pif_pkg::PIF_RX_BIT] = 1'b0;
        end
        // transmit buffer: empty when taken, full on data write
        if (tx_write) begin
            nxt_st.flags[pif_pkg::PIF_TX_BIT] = 1'b0;
        end else if (tx_byte_taken && !st_ff.flags[pif_pkg::PIF_TX_BIT]) begin
            nxt_st.flags[pif_pkg::PIF_TX_BIT] = 1'b1;
            nxt_st.status[pif_pkg::PIF_TXDONE_BIT] = 1'b1;
        end
        nxt_st.status[pif_pkg::PIF_PSP_BIT] = nxt_st.status[pif_pkg::PIF_PSP_BIT]
                                             | psp_access_done;
        nxt_st.status[pif_pkg::PIF_ADC_BIT] = nxt_st.status[pif_pkg::PIF_ADC_BIT]
                                             | adc_conv_done;
        nxt_st.status[pif_pkg::PIF_SSP_BIT] = nxt_st.status[pif_pkg::PIF_SSP_BIT]
                                             | ssp_xfer_done;
        // ****************************************
        // interrupt outputs
        // ****************************************
        nxt_st.cpu_irq = global_irq_gate && nxt_st.ctrl[pif_pkg::PIF_GATE_BIT]
                       && |(nxt_st.flags & nxt_st.enable);
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);
        nxt_st.tx_full = !nxt_st.flags[pif_pkg::PIF_TX_BIT];
        if (reset) begin
            nxt_st = '0;
            nxt_st.flags = pif_pkg::PIF_FLAGS_RST;
            nxt_st.flags[pif_pkg::PIF_TX_BIT] = 1'b1;
            nxt_st.enable = pif_pkg::PIF_ENABLE_RST;
            nxt_st.ctrl = pif_pkg::PIF_CTRL_RST;
            nxt_st.status = pif_pkg::PIF_STATUS_RST;
            nxt_st.mask = pif_pkg::PIF_MASK_RST;
            nxt_st.awready = 1'b1;
            nxt_st.wready = 1'b1;
            nxt_st.arready = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign tx_byte = st_ff.tx_data;
    assign tx_byte_valid = st_ff.tx_full;
    assign cpu_irq = st_ff.cpu_irq;
    assign irq = st_ff.irq;
endmodule : pif_flags

// File: verification/pif_flags_properties.sv
module pif_flags_properties (
    input wire logic clk,
    input wire logic reset,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic tx_byte_taken,
    input wire logic tx_byte_valid,
    input wire logic global_irq_gate,
    input wire logic cpu_irq,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    gate_blocks_irq_a: assert property (!global_irq_gate |=> !cpu_irq)
        else $error("cpu irq with global gate low");
    irq_needs_gate_a: assert property ($rose(cpu_irq) |-> $past(global_irq_gate))
        else $error("cpu irq rose without gate");
    take_empties_tx_a: assert property (tx_byte_taken && tx_byte_valid |=> !tx_byte_valid)
        else $error("tx buffer not emptied");
    tx_stays_full_a: assert property (tx_byte_valid && !tx_byte_taken |=> tx_byte_valid)
        else $error("tx buffer emptied untaken");
    fill_by_write_a: assert property ($rose(tx_byte_valid) |-> $rose(s_axi_bvalid))
        else $error("tx buffer filled without write");
    quiet_after_reset_a: assert property ($fell(reset) |-> !cpu_irq && !irq && !tx_byte_valid)
        else $error("outputs not at reset values");
    upper_read_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");
    read_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read not released");
    write_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write not released");
endmodule : pif_flags_properties

bind pif_flags pif_flags_properties chk (.*);

// File: verification/pif_periph_model.sv
module pif_periph_model (
    input wire logic clk,
    input wire logic [3:0] fire,
    input wire logic [7:0] rx_data,
    input wire logic tx_byte_valid,
    output logic psp_access_done,
    output logic adc_conv_done,
    output logic ssp_xfer_done,
    output logic rx_byte_in,
    output logic [7:0] rx_byte,
    output logic tx_byte_taken
);
    timeunit 1ns;
    timeprecision 1ns;
    int wait_q = 0;
    initial {psp_access_done, adc_conv_done, ssp_xfer_done, rx_byte_in, rx_byte, tx_byte_taken} = '0;
    always @(posedge clk) begin
        {psp_access_done, adc_conv_done, ssp_xfer_done, rx_byte_in} <= fire;
        // data line is meaningless outside an arrival
        rx_byte <= fire[0] ? rx_data : ~rx_byte;
        wait_q <= (tx_byte_valid && !tx_byte_taken) ? wait_q + 1 : 0;
        tx_byte_taken <= tx_byte_valid && !tx_byte_taken && wait_q == 30;
    end
endmodule : pif_periph_model

// File: verification/pif_flags_test.sv
`define chk_eq(got, exp) begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("CHECK FAILED at %0t: %h vs %h", $time, got, exp); \
    end \
end
module pif_flags_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_data = 8'h00, v;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb = 4'hF, fire = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, global_irq_gate = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rresp_q, bresp_q;
    logic [7:0] tx_byte, rx_byte;
    logic tx_byte_valid, cpu_irq, irq, tx_byte_taken;
    logic psp_access_done, adc_conv_done, ssp_xfer_done, rx_byte_in;
    int errors = 0, n_tests = 0, seed = 89235;
    int evb[3] = '{pif_pkg::PIF_PSP_BIT, pif_pkg::PIF_ADC_BIT, pif_pkg::PIF_SSP_BIT};
    pif_flags dut (.*);
    pif_periph_model peer (.*);
    always #20 clk = ~clk;
    // ****
    // helpers
    // ****
    function automatic logic [7:0] stored(input logic [7:0] w);
        return (w & pif_pkg::PIF_WR_MASK) | 8'h10;
    endfunction : stored
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            bresp_q = s_axi_bresp;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!tb);
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic ta, hit;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk);
            ta = s_axi_arvalid && s_axi_arready;
            hit = s_axi_rvalid;
            rdat = s_axi_rdata;
            rresp_q = s_axi_rresp;
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (!hit);
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask : rd
    task automatic chk_flags(input logic [7:0] e);
        rd(pif_pkg::PIF_FLAGS_OFF);
        `chk_eq(rdat[7:0], e)
    endtask : chk_flags
    task automatic pulse(input logic [3:0] f);
        fire <= f;
        @(posedge clk);
        fire <= 4'h0;
        @(posedge clk);
    endtask : pulse
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    // ****
    // scenarios
    // ****
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk_flags(8'h10);
        rd(8'h3C);
        `chk_eq({rresp_q, rdat}, {pif_pkg::PIF_RESP_SLVERR, 32'h0})
        wr(8'h3C, 8'hFF);
        `chk_eq(bresp_q, pif_pkg::PIF_RESP_SLVERR)
        chk_flags(8'h10);
        for (int i = 0; i < 3; i++) begin
            pulse(4'h8 >> i);
            chk_flags(8'h10 | (8'h01 << evb[i]));
            wr(pif_pkg::PIF_FLAGS_OFF, 8'h00);
            chk_flags(8'h10);
        end
        rx_data <= 8'($random(seed));
        pulse(4'h1);
        wr(pif_pkg::PIF_FLAGS_OFF, 8'h00);
        chk_flags(8'h30);
        rd(pif_pkg::PIF_RXDATA_OFF);
        `chk_eq(rdat[7:0], rx_data)
        chk_flags(8'h10);
        v = 8'($random(seed));
        wr(pif_pkg::PIF_TXDATA_OFF, v);
        @(negedge clk);
        `chk_eq({tx_byte_valid, tx_byte}, {1'b1, v})
        @(posedge clk);
        wr(pif_pkg::PIF_FLAGS_OFF, 8'h10);
        chk_flags(8'h00);
        while (tx_byte_valid) @(posedge clk);
        chk_flags(8'h10);
        repeat (4) begin
            v = 8'($random(seed));
            wr(pif_pkg::PIF_FLAGS_OFF, v);
            chk_flags(stored(v));
        end
        wr(pif_pkg::PIF_ENABLE_OFF, 8'hEF);
        wr(pif_pkg::PIF_CTRL_OFF, 8'h01);
        wr(pif_pkg::PIF_FLAGS_OFF, 8'h00);
        global_irq_gate <= 1'b1;
        wr(pif_pkg::PIF_FLAGS_OFF, 8'h40);
        @(negedge clk);
        `chk_eq(cpu_irq, 1'b1)
        @(posedge clk);
        global_irq_gate <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        `chk_eq(cpu_irq, 1'b0)
        @(posedge clk);
        global_irq_gate <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        `chk_eq(cpu_irq, 1'b1)
        @(posedge clk);
        wr(pif_pkg::PIF_CTRL_OFF, 8'h00);
        `chk_eq(bresp_q, pif_pkg::PIF_RESP_OKAY)
        @(negedge clk);
        `chk_eq(cpu_irq, 1'b0)
        @(posedge clk);
        wr(pif_pkg::PIF_STATUS_OFF, 8'hFF);
        wr(pif_pkg::PIF_MASK_OFF, 8'h80);
        pulse(4'h8);
        repeat (2) @(negedge clk);
        `chk_eq(irq, 1'b1)
        @(posedge clk);
        wr(pif_pkg::PIF_STATUS_OFF, 8'h80);
        pulse(4'h4);
        rd(pif_pkg::PIF_STATUS_OFF);
        `chk_eq({irq, rdat[7:0]}, 9'h040)
        give_verdict();
    end
    // generous bound: the sequence needs well under a thousand cycles
    initial begin
        #400000;
        errors++;
        give_verdict();
    end
endmodule : pif_flags_test
